// ==== rtl/counter_array_map.vh ====
`ifndef COUNTER_ARRAY_MAP_VH
`define COUNTER_ARRAY_MAP_VH
// register addresses
`define ADDR_CONTROL    4'h0
`define ADDR_MODE       4'h1
`define ADDR_MOD_IRQ_EN 4'h2
`define ADDR_COUNT_LO   4'h3
`define ADDR_COUNT_HI   4'h4
`define ADDR_IRQ_STATUS 4'h5
`define ADDR_IRQ_MASK   4'h6
// control register fields
`define BIT_OVERFLOW    7
`define BIT_RUN         6
`define BIT_RESERVED    5
`define NUM_MODULES     5
// mode register fields
`define BIT_OVF_IRQ_EN  0
// reset values and counter maximum
`define CONTROL_RESET   8'h00
`define MODE_RESET      8'h00
`define MASK_RESET      8'h00
`define COUNT_MAX       16'hffff
`endif

// ==== rtl/shared_counter.v ====
`timescale 1ns/1ps
`include "counter_array_map.vh"
// 16-bit free counter, advances only while run is high
module shared_counter (
  // clock and reset
  input  wire        sys_clk,
  input  wire        reset,
  // control
  input  wire        run,
  // state
  output reg  [15:0] count_r,
  output reg         rollover_r
);
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_r    <= 16'h0000;
      rollover_r <= 1'b0;
    end else begin
      rollover_r <= run && (count_r == `COUNT_MAX);
      if (run)
        count_r <= count_r + 16'h0001;
    end
  end
endmodule // shared_counter

// ==== rtl/sticky_flags.v ====
`timescale 1ns/1ps
// sticky flags: hardware set wins over a same-cycle clear
module sticky_flags #(
  parameter W = 8
) (
  // clock and reset
  input  wire         sys_clk,
  input  wire         reset,
  // events and clears
  input  wire [W-1:0] set_in,
  input  wire [W-1:0] clr_in,
  // state
  output reg  [W-1:0] flags_r
);
  always @(posedge sys_clk or posedge reset) begin
    if (reset)
      flags_r <= {W{1'b0}};
    else
      flags_r <= set_in | (flags_r & ~clr_in);
  end
endmodule // sticky_flags

// ==== rtl/counter_array_control.v ====
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "counter_array_map.vh"
// Function
// - rollover sets overflow flag bit 7; raises irq_request_r only with overflow enable, irq_r via status and mask bit 5
// - overflow flag set by hardware or software 1; cleared only by software 0
// - run bit 6 advances counter when 1, holds it when 0; software only
// - module n event sets flag bit n; only software 0 clears it
// - module flag raises irq_request_r only while that module's enable bit is 1; irq_r follows status and mask bit n
module counter_array_control (
  // clock and reset
  input  wire       sys_clk,
  input  wire       reset,
  // register port
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata_r,
  // module events from compare/capture datapaths
  input  wire [4:0] module_event,
  // outputs to surrounding logic
  output reg        counter_run_r,
  output reg        irq_request_r,
  output reg        irq_r
);
  localparam N = `NUM_MODULES;
  localparam [7:0] CTRL_RST = `CONTROL_RESET;
  localparam [7:0] MASK_RST = `MASK_RESET;

  // control register fields, each in a flop of its own
  reg         run_r;
  reg         ovf_r;
  reg  [4:0]  mod_flag_r;

  // other software registers
  reg  [7:0]  mode_r;
  reg  [4:0]  mod_en_r;
  reg  [6:0]  mask_r;

  // next values
  reg         run_nxt;
  reg         ovf_nxt;
  reg  [4:0]  mod_flag_nxt;
  reg  [7:0]  mode_nxt;
  reg  [4:0]  mod_en_nxt;
  reg  [6:0]  mask_nxt;
  reg  [7:0]  rdata_nxt;
  reg         counter_run_nxt;
  reg         irq_request_nxt;
  reg         irq_nxt;

  // counter, status and read view
  wire [15:0] count;
  wire        rollover;
  wire [6:0]  irq_stat;
  wire [6:0]  stat_set;
  wire [6:0]  stat_clr;
  wire [7:0]  ctrl_view;

  // decoded strobes and pending requests
  wire        wr_ctrl;
  wire        wr_mode;
  wire        wr_mod_en;
  wire        wr_stat;
  wire        wr_mask;
  wire        ovf_pending;
  wire        module_pending;

  // strobe qualified by one register address
  function hit;
    input       strobe;
    input [3:0] a;
    input [3:0] target;
    begin
      hit = strobe && (a == target);
    end
  endfunction

  // a written value replaces the flag, a same-cycle event still sets it
  // trade-off: a written 1 sets a flag too, so software may force it
  function flag_bit;
    input cur;
    input wval;
    input we;
    input ev;
    begin
      flag_bit = (we ? wval : cur) | ev;
    end
  endfunction

  // any flag whose enable is set
  function any_set;
    input [6:0] flags;
    input [6:0] enables;
    begin
      any_set = |(flags & enables);
    end
  endfunction

  // read multiplexer, unmapped addresses read 0
  function [7:0] rd_mux;
    input [3:0] a;
    begin
      case (a)
        `ADDR_CONTROL:    rd_mux = ctrl_view;
        `ADDR_MODE:       rd_mux = mode_r;
        `ADDR_MOD_IRQ_EN: rd_mux = {3'h0, mod_en_r};
        `ADDR_COUNT_LO:   rd_mux = count[7:0];
        `ADDR_COUNT_HI:   rd_mux = count[15:8];
        `ADDR_IRQ_STATUS: rd_mux = {1'b0, irq_stat};
        `ADDR_IRQ_MASK:   rd_mux = {1'b0, mask_r};
        default:          rd_mux = 8'h00;
      endcase
    end
  endfunction

  // write strobes, one per writable register
  assign wr_ctrl   = hit(wr, addr, `ADDR_CONTROL);
  assign wr_mode   = hit(wr, addr, `ADDR_MODE);
  assign wr_mod_en = hit(wr, addr, `ADDR_MOD_IRQ_EN);
  assign wr_stat   = hit(wr, addr, `ADDR_IRQ_STATUS);
  assign wr_mask   = hit(wr, addr, `ADDR_IRQ_MASK);

  // bit 5 is not stored: a stray write of 1 can never stick
  assign ctrl_view = {ovf_r, run_r, 1'b0, mod_flag_r};

  // requests gated by their enables before the output flop
  // the request output ignores the mask; the status path has its own
  assign ovf_pending    = ovf_r & mode_r[`BIT_OVF_IRQ_EN];
  assign module_pending = any_set({2'b00, mod_flag_r},
                                  {2'b00, mod_en_r});

  // a cleared run bit stops the count one cycle later
  shared_counter u_counter (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .run        (run_r),
    .count_r    (count),
    .rollover_r (rollover)
  );

  // run bit: only software moves it, hardware never clears it
  always @* begin
    run_nxt = run_r;
    if (wr_ctrl)
      run_nxt = wdata[`BIT_RUN];
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      run_r <= CTRL_RST[`BIT_RUN];
    end else begin
      run_r <= run_nxt;
    end
  end

  // overflow flag: no hardware path ever clears it
  always @* begin
    ovf_nxt = flag_bit(ovf_r, wdata[`BIT_OVERFLOW], wr_ctrl,
                       rollover);
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ovf_r <= CTRL_RST[`BIT_OVERFLOW];
    end else begin
      ovf_r <= ovf_nxt;
    end
  end

  // module flags: events set them, only a written 0 clears them
  always @* begin
    mod_flag_nxt[0] = flag_bit(mod_flag_r[0], wdata[0], wr_ctrl,
                               module_event[0]);
    mod_flag_nxt[1] = flag_bit(mod_flag_r[1], wdata[1], wr_ctrl,
                               module_event[1]);
    mod_flag_nxt[2] = flag_bit(mod_flag_r[2], wdata[2], wr_ctrl,
                               module_event[2]);
    mod_flag_nxt[3] = flag_bit(mod_flag_r[3], wdata[3], wr_ctrl,
                               module_event[3]);
    mod_flag_nxt[4] = flag_bit(mod_flag_r[4], wdata[4], wr_ctrl,
                               module_event[4]);
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mod_flag_r <= CTRL_RST[N-1:0];
    end else begin
      mod_flag_r <= mod_flag_nxt;
    end
  end

  // mode register: bit 0 gates the overflow request
  always @* begin
    mode_nxt = mode_r;
    if (wr_mode)
      mode_nxt = wdata;
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_r <= `MODE_RESET;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // per-module request enables
  always @* begin
    mod_en_nxt = mod_en_r;
    if (wr_mod_en)
      mod_en_nxt = wdata[4:0];
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mod_en_r <= 5'h00;
    end else begin
      mod_en_r <= mod_en_nxt;
    end
  end

  // interrupt mask, same layout as status
  always @* begin
    mask_nxt = mask_r;
    if (wr_mask)
      mask_nxt = wdata[6:0];
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mask_r <= MASK_RST[6:0];
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // status bit 5 mirrors rollover so it can be masked apart; bit 6 unused
  assign stat_set = {1'b0, rollover, module_event};
  assign stat_clr = wr_stat ? wdata[6:0] : 7'h00;

  sticky_flags #(.W(7)) u_status (
    .sys_clk (sys_clk),
    .reset   (reset),
    .set_in  (stat_set),
    .clr_in  (stat_clr),
    .flags_r (irq_stat)
  );

  // read data stand one cycle only, 0 otherwise
  always @* begin
    rdata_nxt = 8'h00;
    if (rd)
      rdata_nxt = rd_mux(addr);
  end

  always @* begin
    counter_run_nxt = run_r;
  end

  always @* begin
    irq_request_nxt = ovf_pending | module_pending;
  end

  always @* begin
    irq_nxt = any_set(irq_stat, mask_r);
  end

  // every output leaves straight from a flop
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      counter_run_r <= 1'b0;
    end else begin
      counter_run_r <= counter_run_nxt;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_request_r <= 1'b0;
    end else begin
      irq_request_r <= irq_request_nxt;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end
endmodule // counter_array_control

// ==== tb/counter_array_control_properties.sv ====
`timescale 1ns/1ps
module counter_array_control_properties (
  input wire       sys_clk,
  input wire       reset,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata_r,
  input wire [4:0] module_event,
  input wire       counter_run_r,
  input wire       irq_request_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire wc = wr && addr == 4'h0;
  wire rc = rd && addr == 4'h0;
  a_run_write: assert property (
    wc |-> ##2 counter_run_r == $past(wdata[6], 2)) else $error("run");
  a_run_held: assert property (
    counter_run_r != $past(counter_run_r) |-> $past(wc, 2)) else $error("run");
  a_event_set: assert property (
    module_event[0] ##1 !wr ##1 rc |=> rdata_r[0]) else $error("event");
  a_set_wins: assert property (
    wc && !wdata[2] && module_event[2] ##1 !wr ##1 rc |=> rdata_r[2])
    else $error("event lost");
  a_flag_kept: assert property (
    rc ##1 rdata_r[7] && !wr ##1 !wr ##1 rc |=> rdata_r[7])
    else $error("overflow");
  a_ovf_irq: assert property (
    wc && wdata[7] ##1 !wr ##1 wr && addr == 4'h1 && wdata[0]
    |-> ##[1:2] irq_request_r)
    else $error("overflow irq");
  a_module_irq: assert property (
    wr && addr == 4'h2 && wdata[0] ##1 !wr ##1 module_event[0]
    |-> ##[1:2] irq_request_r)
    else $error("module irq");
  cover property (wc && wdata[6]);
  cover property (rc ##1 rdata_r[7]);
  cover property (irq_request_r);
endmodule // counter_array_control_properties
bind counter_array_control counter_array_control_properties u_props (
  .sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata_r(rdata_r), .module_event(module_event),
  .counter_run_r(counter_run_r), .irq_request_r(irq_request_r));

// ==== tb/counter_array_control_bench.sv ====
`timescale 1ns/1ps
module counter_array_control_bench;
  logic       sys_clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [4:0] module_event = 5'h00;
  wire  [7:0] rdata_r;
  wire        counter_run_r, irq_request_r, irq_r;
  int         n_errors = 0, checks = 0;
  logic [7:0] lo, hi;
  always #5 sys_clk = ~sys_clk;
  counter_array_control u_counter_array_control (.sys_clk(sys_clk),
    .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_r(rdata_r), .module_event(module_event),
    .counter_run_r(counter_run_r), .irq_request_r(irq_request_r),
    .irq_r(irq_r));
  task chk(input string n, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task w(input logic [3:0] a, input logic [7:0] d, input logic [4:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    module_event <= v;
    @(posedge sys_clk);
    wr <= 1'b0;
    module_event <= 5'h00;
  endtask
  task rv(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    v = rdata_r;
  endtask
  task r(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rv(a, v);
    chk("rdata", e, v);
  endtask
  task t(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task complete_run;
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // full run is about 66k cycles
  initial begin
    #1000000;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    r(4'h0, 8'h00);
    w(4'h0, 8'h40, 5'h00);
    t(2);
    chk("run", 8'h01, {7'h00, counter_run_r});
    w(4'h1, 8'h00, 5'h1f);
    r(4'h0, 8'h5f);
    w(4'h0, 8'h40, 5'h04);
    r(4'h0, 8'h44);
    w(4'h0, 8'hc0, 5'h00);
    w(4'h1, 8'h01, 5'h00);
    t(3);
    chk("irq_request", 8'h01, {7'h00, irq_request_r});
    w(4'h1, 8'h00, 5'h00);
    r(4'h0, 8'hc0);
    r(4'h0, 8'hc0);
    w(4'h2, 8'h01, 5'h00);
    w(4'h1, 8'h00, 5'h01);
    t(3);
    chk("irq_request", 8'h01, {7'h00, irq_request_r});
    w(4'h0, 8'h40, 5'h00);
    // long enough for one full wrap of the counter
    t(65540);
    r(4'h0, 8'hc0);
    w(4'h6, 8'h01, 5'h00);
    t(2);
    chk("irq", 8'h01, {7'h00, irq_r});
    w(4'h5, 8'h3f, 5'h00);
    t(2);
    chk("irq", 8'h00, {7'h00, irq_r});
    r(4'hf, 8'h00);
    rv(4'h3, lo);
    rv(4'h3, hi);
    checks++;
    if (hi === lo) begin
      n_errors++;
      $display("ERROR count_lo expected change seen %h", hi);
    end
    w(4'h0, 8'h00, 5'h00);
    rv(4'h3, lo);
    rv(4'h4, hi);
    t(20);
    r(4'h3, lo);
    r(4'h4, hi);
    r(4'h0, 8'h00);
    complete_run;
  end
endmodule // counter_array_control_bench
